// ### pkg/ufp_map.vh
// register map, field positions and reset values of the fifo port buffer control
// assumes inclusion by bare name from design files under core/
`ifndef UFP_MAP_VH
`define UFP_MAP_VH

// ----------------------------------------------------------------------
// register indices and byte addresses (apb, one word per register)
// ----------------------------------------------------------------------
`define UFP_IDX_CPU_CTRL 10'h02e
`define UFP_IDX_DMA_CFG 10'h030
`define UFP_ADDR_CPU_CTRL ({`UFP_IDX_CPU_CTRL, 2'b00})
`define UFP_ADDR_DMA_CFG ({`UFP_IDX_DMA_CFG, 2'b00})
`define UFP_ADDR_RX_LEN 12'h100
`define UFP_ADDR_INT_STAT 12'h104
`define UFP_ADDR_INT_MASK 12'h108

// ----------------------------------------------------------------------
// engine-side control register fields
// ----------------------------------------------------------------------
`define UFP_B_TOGGLE 15
`define UFP_B_ENG_CLEAR 14
`define UFP_B_ENG_BUSY 13

// ----------------------------------------------------------------------
// dma port configuration register fields
// ----------------------------------------------------------------------
`define UFP_B_CNT_MODE 15
`define UFP_B_REWIND 14
`define UFP_B_AUTO_CLR 13
`define UFP_B_WIDTH 10
`define UFP_B_TXN_EN 9
`define UFP_B_TXN_CLR 8
`define UFP_PIPE_MSB 2
`define UFP_PIPE_LSB 0
`define UFP_CFG_STORE_MASK 16'ha607
`define UFP_CFG_RESET 16'h0000
`define UFP_PIPE_OFF 3'h0
`define UFP_PIPE_BAD 3'h7

// ----------------------------------------------------------------------
// interrupt status bits and length counter
// ----------------------------------------------------------------------
`define UFP_INT_W 4
`define UFP_INT_BUF_READY 0
`define UFP_INT_ENG_CLEAR 1
`define UFP_INT_AUTO_CLR 2
`define UFP_INT_LEN_DONE 3
`define UFP_INT_RESET 4'h0
`define UFP_LEN_W 10
`define UFP_LEN_RESET 10'h000
`define UFP_LEN_STEP_BYTE 10'h001
`define UFP_LEN_STEP_WORD 10'h002

`endif

// ### core/ufp_irq.v
// sticky interrupt status with write-one-to-clear and a mask
// assumes event pulses and clear strobes come from logic on mclk
`timescale 1ns/1ps
`default_nettype none
`include "ufp_map.vh"

module ufp_irq (
  input wire mclk,
  input wire reset,
  input wire [`UFP_INT_W-1:0] event_in,
  input wire clear_wr,
  input wire [`UFP_INT_W-1:0] clear_bits,
  input wire mask_wr,
  input wire [`UFP_INT_W-1:0] mask_bits,
  output reg [`UFP_INT_W-1:0] status_q,
  output reg [`UFP_INT_W-1:0] mask_q,
  output reg irq_q
);
  wire [`UFP_INT_W-1:0] status_d;
  wire [`UFP_INT_W-1:0] mask_d;

  // a new event wins over a clear in the same cycle
  assign status_d = event_in | (status_q & ~(clear_wr ? clear_bits : `UFP_INT_RESET));
  assign mask_d = mask_wr ? mask_bits : mask_q;

  always @(posedge mclk) begin
    if (reset) begin
      status_q <= `UFP_INT_RESET;
      mask_q <= `UFP_INT_RESET;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= |(status_d & mask_d);
    end
  end
endmodule
`default_nettype wire

// ### core/ufp_len.v
// receive length counter of the dma port
// assumes load, read and last strobes are single-cycle pulses on mclk
`timescale 1ns/1ps
`default_nettype none
`include "ufp_map.vh"

module ufp_len (
  input wire mclk,
  input wire reset,
  input wire load,
  input wire [`UFP_LEN_W-1:0] load_val,
  input wire rd,
  input wire last,
  input wire count_mode,
  input wire wide,
  output reg [`UFP_LEN_W-1:0] len_q
);
  wire [`UFP_LEN_W-1:0] step;
  reg [`UFP_LEN_W-1:0] len_d;

  assign step = wide ? `UFP_LEN_STEP_WORD : `UFP_LEN_STEP_BYTE;

  always @* begin
    len_d = len_q;
    if (load) begin
      len_d = load_val;
    end else if (rd && last) begin
      len_d = `UFP_LEN_RESET; // RQ10
    end else if (rd && count_mode) begin
      // saturate so a stray extra read cannot wrap the count
      len_d = (len_q > step) ? len_q - step : `UFP_LEN_RESET; // RQ10
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      len_q <= `UFP_LEN_RESET;
    end else begin
      len_q <= len_d;
    end
  end
endmodule
`default_nettype wire

// ### core/ufp_ctrl.v
// fifo port buffer control: engine-side control and dma port configuration
// assumes apb master on mclk, engine and dma strobes from logic on mclk
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ufp_map.vh"

// Contract
// RQ1: toggle write in continuous mode, buffer not full, hands engine buffer over
// RQ2: each toggle hand-over raises the buffer ready interrupt
// RQ3: toggle acts only on out pipes, ignored on the default control pipe
// RQ4: zero writes to action bits do nothing; action bits read zero
// RQ5: engine clear on in pipe empties engine buffer and hands it over
// RQ6: software sets nak and waits for busy zero before engine clear
// RQ7: busy flag reads engine access state; meaningless on default control pipe
// RQ8: reserved bits read zero; software writes zero
// RQ9: both registers reset to zero on hardware and software reset
// RQ10: receive length holds then clears, or counts down per read
// RQ11: rewind resets read pointer for out, write pointer for in
// RQ12: auto clear enable clears dma buffer once all data read
// RQ13: width bit selects byte or sixteen-bit dma port accesses
// RQ14: counter enable bit turns the transaction counter on or off
// RQ15: counter clear write resets the transaction counter
// RQ16: pipe field zero disables port, one to six select pipes, seven invalid
// RQ17: toggle on out pipe also sets processor-port buffer valid flag
// RQ18: pipe value seven treated as disabled port with no buffer access
module ufp_ctrl (
  input wire mclk,
  input wire reset,
  input wire soft_reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] cpu_pipe_sel,
  input wire [6:1] pipe_dir_out,
  input wire continuous_mode,
  input wire cpu_buf_full,
  input wire engine_busy,
  input wire dma_rd,
  input wire dma_last,
  input wire rx_len_load,
  input wire [`UFP_LEN_W-1:0] rx_len_val,
  output reg buffer_toggle_q,
  output reg buffer_valid_set_q,
  output reg engine_side_clear_q,
  output reg rewind_rd_ptr_q,
  output reg rewind_wr_ptr_q,
  output reg auto_clear_q,
  output reg port_access_width_q,
  output reg txn_counter_enable_q,
  output reg txn_counter_clear_q,
  output reg [2:0] dma_pipe_q,
  output reg dma_port_en_q,
  output wire irq
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // pipe zero stands for the default control pipe on the processor port
  function pipe_valid;
    input [2:0] sel;
    begin
      pipe_valid = (sel != `UFP_PIPE_OFF) && (sel != `UFP_PIPE_BAD);
    end
  endfunction

  function pipe_out;
    input [2:0] sel;
    input [6:1] dir;
    begin
      pipe_out = 1'b0;
      if (pipe_valid(sel)) begin
        pipe_out = dir[sel];
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  // read data is sampled in the setup cycle so prdata comes from a flop;
  // pready rises in the access cycle, one wait-free access per transfer
  wire setup_ph;
  wire access_ph;
  wire wr_en;
  wire hit_cpu;
  wire hit_dma;
  wire hit_len;
  wire hit_stat;
  wire hit_mask;
  wire hit_any;
  wire [15:0] wd;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && pready;
  assign wr_en = access_ph && pwrite && !pslverr;
  assign hit_cpu = (paddr == `UFP_ADDR_CPU_CTRL);
  assign hit_dma = (paddr == `UFP_ADDR_DMA_CFG);
  assign hit_len = (paddr == `UFP_ADDR_RX_LEN);
  assign hit_stat = (paddr == `UFP_ADDR_INT_STAT);
  assign hit_mask = (paddr == `UFP_ADDR_INT_MASK);
  assign hit_any = hit_cpu | hit_dma | hit_len | hit_stat | hit_mask;
  assign wd = pwdata[15:0];

  // ----------------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------------
  reg [15:0] cfg_q;
  reg [15:0] cfg_d;
  wire cfg_wr;
  wire cpu_wr;
  wire regs_clr;
  wire [2:0] cur_pipe;
  wire dma_live;
  wire dma_is_out;

  assign cfg_wr = wr_en && hit_dma;
  assign cpu_wr = wr_en && hit_cpu;
  assign regs_clr = reset || soft_reset; // RQ9
  assign cur_pipe = cfg_q[`UFP_PIPE_MSB:`UFP_PIPE_LSB];
  assign dma_live = pipe_valid(cur_pipe); // RQ16 RQ18
  assign dma_is_out = pipe_out(cur_pipe, pipe_dir_out);

  always @* begin
    cfg_d = cfg_q;
    if (cfg_wr) begin
      // action and reserved bits are never stored
      cfg_d = wd & `UFP_CFG_STORE_MASK; // RQ4 RQ8
    end
  end

  always @(posedge mclk) begin
    if (regs_clr) begin
      cfg_q <= `UFP_CFG_RESET; // RQ9
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------------
  // engine-side actions
  // ----------------------------------------------------------------------
  wire cpu_is_dcp;
  wire cpu_is_out;
  wire toggle_go;
  wire eng_clr_go;

  assign cpu_is_dcp = (cpu_pipe_sel == `UFP_PIPE_OFF);
  assign cpu_is_out = pipe_out(cpu_pipe_sel, pipe_dir_out);
  // a zero in the action bit does nothing; dcp and in pipes ignore it
  assign toggle_go = cpu_wr && wd[`UFP_B_TOGGLE] && continuous_mode
    && !cpu_buf_full && cpu_is_out && !cpu_is_dcp; // RQ1 RQ3 RQ4
  // on out pipes the clear is inhibited; software keeps the nak order
  assign eng_clr_go = cpu_wr && wd[`UFP_B_ENG_CLEAR] && !cpu_is_dcp
    && pipe_valid(cpu_pipe_sel) && !cpu_is_out; // RQ5 RQ6

  // ----------------------------------------------------------------------
  // dma port actions
  // ----------------------------------------------------------------------
  wire [2:0] new_pipe;
  wire new_live;
  wire new_out;
  wire rew_go;
  wire dma_rd_ok;
  wire auto_go;

  // a rewind written with a new pipe acts on the new pipe
  assign new_pipe = wd[`UFP_PIPE_MSB:`UFP_PIPE_LSB];
  assign new_live = pipe_valid(new_pipe);
  assign new_out = pipe_out(new_pipe, pipe_dir_out);
  assign rew_go = cfg_wr && wd[`UFP_B_REWIND] && new_live; // RQ11 RQ18
  // a port on pipe zero or seven performs no buffer access
  assign dma_rd_ok = dma_rd && dma_live && dma_is_out; // RQ18
  assign auto_go = dma_rd_ok && dma_last && cfg_q[`UFP_B_AUTO_CLR]; // RQ12

  always @(posedge mclk) begin
    if (regs_clr) begin
      buffer_toggle_q <= 1'b0;
      buffer_valid_set_q <= 1'b0;
      engine_side_clear_q <= 1'b0;
      rewind_rd_ptr_q <= 1'b0;
      rewind_wr_ptr_q <= 1'b0;
      auto_clear_q <= 1'b0;
      txn_counter_clear_q <= 1'b0;
    end else begin
      buffer_toggle_q <= toggle_go; // RQ1
      buffer_valid_set_q <= toggle_go; // RQ17
      engine_side_clear_q <= eng_clr_go; // RQ5
      rewind_rd_ptr_q <= rew_go && new_out; // RQ11
      rewind_wr_ptr_q <= rew_go && !new_out; // RQ11
      auto_clear_q <= auto_go; // RQ12
      txn_counter_clear_q <= cfg_wr && wd[`UFP_B_TXN_CLR]; // RQ15
    end
  end

  // level outputs mirror the configuration as it will stand next cycle
  always @(posedge mclk) begin
    if (regs_clr) begin
      port_access_width_q <= 1'b0;
      txn_counter_enable_q <= 1'b0;
      dma_pipe_q <= `UFP_PIPE_OFF;
      dma_port_en_q <= 1'b0;
    end else begin
      port_access_width_q <= cfg_d[`UFP_B_WIDTH]; // RQ13
      txn_counter_enable_q <= cfg_d[`UFP_B_TXN_EN]; // RQ14
      dma_pipe_q <= cfg_d[`UFP_PIPE_MSB:`UFP_PIPE_LSB]; // RQ16
      dma_port_en_q <= pipe_valid(cfg_d[`UFP_PIPE_MSB:`UFP_PIPE_LSB]); // RQ16 RQ18
    end
  end

  // ----------------------------------------------------------------------
  // receive length
  // ----------------------------------------------------------------------
  wire [`UFP_LEN_W-1:0] rx_len;

  ufp_len u_len (
    .mclk(mclk),
    .reset(regs_clr),
    .load(rx_len_load),
    .load_val(rx_len_val),
    .rd(dma_rd_ok),
    .last(dma_last),
    .count_mode(cfg_q[`UFP_B_CNT_MODE]),
    .wide(cfg_q[`UFP_B_WIDTH]),
    .len_q(rx_len)
  );

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  wire [`UFP_INT_W-1:0] int_ev;
  wire [`UFP_INT_W-1:0] int_stat;
  wire [`UFP_INT_W-1:0] int_mask;

  assign int_ev[`UFP_INT_BUF_READY] = toggle_go; // RQ2
  assign int_ev[`UFP_INT_ENG_CLEAR] = eng_clr_go;
  assign int_ev[`UFP_INT_AUTO_CLR] = auto_go;
  assign int_ev[`UFP_INT_LEN_DONE] = dma_rd_ok && dma_last;

  // interrupt state survives a software reset; only mclk reset clears it
  ufp_irq u_irq (
    .mclk(mclk),
    .reset(reset),
    .event_in(int_ev),
    .clear_wr(wr_en && hit_stat),
    .clear_bits(pwdata[`UFP_INT_W-1:0]),
    .mask_wr(wr_en && hit_mask),
    .mask_bits(pwdata[`UFP_INT_W-1:0]),
    .status_q(int_stat),
    .mask_q(int_mask),
    .irq_q(irq)
  );

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h0000_0000;
    if (hit_cpu) begin
      // busy reads zero on the default control pipe, where it means nothing
      rd_d[`UFP_B_ENG_BUSY] = engine_busy && !cpu_is_dcp; // RQ7 RQ4 RQ8
    end else if (hit_dma) begin
      rd_d[15:0] = cfg_q; // RQ4 RQ8
    end else if (hit_len) begin
      rd_d[`UFP_LEN_W-1:0] = rx_len;
    end else if (hit_stat) begin
      rd_d[`UFP_INT_W-1:0] = int_stat;
    end else if (hit_mask) begin
      rd_d[`UFP_INT_W-1:0] = int_mask;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr <= !hit_any;
      end else if (access_ph) begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### dv/ufp_ctrl_assertions.sv
// checker for the fifo port buffer control
// assumes a bind onto ufp_ctrl, engine ctrl at 0x0b8 and dma cfg at 0x0c0
`timescale 1ns/1ps
`default_nettype none
module ufp_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [2:0] cpu_pipe_sel,
  input wire logic [6:1] pipe_dir_out,
  input wire logic continuous_mode,
  input wire logic cpu_buf_full,
  input wire logic engine_busy,
  input wire logic buffer_toggle_q,
  input wire logic buffer_valid_set_q,
  input wire logic engine_side_clear_q,
  input wire logic rewind_rd_ptr_q,
  input wire logic rewind_wr_ptr_q,
  input wire logic [2:0] dma_pipe_q,
  input wire logic dma_port_en_q
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  logic cwr;
  logic pv;
  logic dout;
  logic tok;
  assign cwr = psel && penable && pwrite && paddr == 12'h0b8 && !soft_reset;
  assign pv = cpu_pipe_sel != 3'h0 && cpu_pipe_sel != 3'h7;
  // guard first, an out-of-range index would read unknown
  assign dout = pv && pipe_dir_out[cpu_pipe_sel];
  assign tok = cwr && pwdata[15] && dout && continuous_mode && !cpu_buf_full;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_TGL_SET: assert property (tok |=> buffer_toggle_q)
    else $error("toggle missing");
  AST_TGL_ONLY: assert property (buffer_toggle_q |-> $past(tok))
    else $error("toggle without cause");
  AST_VALID_SET: assert property (buffer_toggle_q || buffer_valid_set_q |->
    buffer_toggle_q && buffer_valid_set_q) else $error("valid set apart");
  AST_CLR_SET: assert property (cwr && pwdata[14] && pv && !dout |=> engine_side_clear_q)
    else $error("engine clear missing");
  AST_CLR_ONLY: assert property (engine_side_clear_q |-> $past(cwr && pwdata[14] && pv && !dout))
    else $error("engine clear without cause");
  AST_BUSY_RD: assert property (pready && !pwrite && paddr == 12'h0b8 |->
    prdata[13] == $past(engine_busy && cpu_pipe_sel != 3'h0)) else $error("busy bad");
  AST_CPU_RSV: assert property (pready && !pwrite && paddr == 12'h0b8 |->
    prdata[15:14] == 2'h0 && prdata[12:0] == 13'h0) else $error("cpu rsv");
  AST_CFG_RSV: assert property (pready && !pwrite && paddr == 12'h0c0 |->
    prdata[14] == 1'b0 && prdata[12:11] == 2'h0 && prdata[8:3] == 6'h0) else $error("cfg rsv");
  AST_PIPE_EN: assert property (dma_port_en_q == (dma_pipe_q != 3'h0 && dma_pipe_q != 3'h7))
    else $error("port enable bad");
  AST_REW_DIR: assert property (rewind_rd_ptr_q || rewind_wr_ptr_q |-> dma_port_en_q &&
    rewind_rd_ptr_q == pipe_dir_out[dma_pipe_q] && !(rewind_rd_ptr_q && rewind_wr_ptr_q))
    else $error("rewind bad");
  AST_RST: assert property ($past(reset || soft_reset) |-> dma_pipe_q == 3'h0 && !dma_port_en_q)
    else $error("reset value bad");
endmodule
bind ufp_ctrl ufp_chk u_chk (.mclk(mclk), .reset(reset), .soft_reset(soft_reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .cpu_pipe_sel(cpu_pipe_sel), .pipe_dir_out(pipe_dir_out),
  .continuous_mode(continuous_mode), .cpu_buf_full(cpu_buf_full), .engine_busy(engine_busy),
  .buffer_toggle_q(buffer_toggle_q), .buffer_valid_set_q(buffer_valid_set_q),
  .engine_side_clear_q(engine_side_clear_q), .rewind_rd_ptr_q(rewind_rd_ptr_q),
  .rewind_wr_ptr_q(rewind_wr_ptr_q), .dma_pipe_q(dma_pipe_q), .dma_port_en_q(dma_port_en_q));
`default_nettype wire

// ### dv/ufp_eng_model.sv
// model of the serial engine and dma side strobes
// assumes callers enter its tasks just after a rising mclk edge
`timescale 1ns/1ps
`default_nettype none
`include "ufp_map.vh"
module ufp_eng_model (
  input wire logic mclk,
  output logic [6:1] pipe_dir_out,
  output logic continuous_mode,
  output logic cpu_buf_full,
  output logic engine_busy,
  output logic dma_rd,
  output logic dma_last,
  output logic rx_len_load,
  output logic [`UFP_LEN_W-1:0] rx_len_val
);
  // ----------------------------------------------------------------------
  // levels and strobes
  // ----------------------------------------------------------------------
  initial begin
    {pipe_dir_out, continuous_mode, cpu_buf_full, engine_busy} = 9'h0;
    {dma_rd, dma_last, rx_len_load, rx_len_val} = 13'h0;
  end
  // busy follows the bz argument directly; no nak handshake is modelled
  task set(input logic [6:1] d, input logic cm, input logic fu, input logic bz);
    pipe_dir_out <= d;
    continuous_mode <= cm;
    cpu_buf_full <= fu;
    engine_busy <= bz;
  endtask
  task rd(input logic l);
    dma_rd <= 1'b1;
    dma_last <= l;
    @(posedge mclk);
    dma_rd <= 1'b0;
    dma_last <= 1'b0;
    @(posedge mclk);
  endtask
  task load(input logic [`UFP_LEN_W-1:0] v);
    rx_len_load <= 1'b1;
    rx_len_val <= v;
    @(posedge mclk);
    rx_len_load <= 1'b0;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// testbench of the fifo port buffer control
// assumes ufp_ctrl as an apb slave on mclk, engine side from ufp_eng_model
`timescale 1ns/1ps
`default_nettype none
`include "ufp_map.vh"
module tb_top;
  // ----------------------------------------------------------------------
  // signals and bus tasks
  // ----------------------------------------------------------------------
  localparam logic [11:0] a_cpu = `UFP_ADDR_CPU_CTRL;
  localparam logic [11:0] a_cfg = `UFP_ADDR_DMA_CFG;
  localparam logic [11:0] a_len = `UFP_ADDR_RX_LEN;
  localparam logic [11:0] a_st = `UFP_ADDR_INT_STAT;
  localparam logic [11:0] a_mk = `UFP_ADDR_INT_MASK;
  logic mclk, reset, soft_reset, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] cpu_pipe_sel;
  logic [6:1] dir;
  logic cm, fu, bz, drd, dl, ld, wd, ten, pen;
  logic [9:0] lv;
  int fail_count, checked;
  logic p_tgl, p_val, p_clr, p_rrd, p_rwr, p_abc, p_tcl;
  logic [2:0] dpipe;
  int n_tgl, n_val, n_clr, n_rrd, n_rwr, n_abc, n_tcl;
  ufp_eng_model eng (.mclk(mclk), .pipe_dir_out(dir), .continuous_mode(cm), .cpu_buf_full(fu),
    .engine_busy(bz), .dma_rd(drd), .dma_last(dl), .rx_len_load(ld), .rx_len_val(lv));
  ufp_ctrl uut (.mclk(mclk), .reset(reset), .soft_reset(soft_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_pipe_sel(cpu_pipe_sel), .pipe_dir_out(dir),
    .continuous_mode(cm), .cpu_buf_full(fu), .engine_busy(bz), .dma_rd(drd), .dma_last(dl),
    .rx_len_load(ld), .rx_len_val(lv), .buffer_toggle_q(p_tgl), .buffer_valid_set_q(p_val),
    .engine_side_clear_q(p_clr), .rewind_rd_ptr_q(p_rrd), .rewind_wr_ptr_q(p_rwr),
    .auto_clear_q(p_abc), .port_access_width_q(wd), .txn_counter_enable_q(ten),
    .txn_counter_clear_q(p_tcl), .dma_pipe_q(dpipe), .dma_port_en_q(pen), .irq(irq));
  // pulses stand one cycle only, so they are tallied at every edge instead of polled
  always @(posedge mclk) begin
    n_tgl <= n_tgl + int'(p_tgl === 1'b1);
    n_val <= n_val + int'(p_val === 1'b1);
    n_clr <= n_clr + int'(p_clr === 1'b1);
    n_rrd <= n_rrd + int'(p_rrd === 1'b1);
    n_rwr <= n_rwr + int'(p_rwr === 1'b1);
    n_abc <= n_abc + int'(p_abc === 1'b1);
    n_tcl <= n_tcl + int'(p_tcl === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // no wait count is assumed, only the watchdog ends a dead slave
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    rd(a_cpu, 32'h0);
    rd(a_cfg, 32'h0);
    rd(12'h0fc, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task t_toggle;
    logic [2:0] sl [6] = '{1, 1, 1, 0, 3, 1};
    logic mo [6] = '{1, 1, 1, 1, 1, 0};
    logic fl [6] = '{0, 0, 1, 0, 0, 0};
    logic [15:0] dt [6] = '{16'h8000, 16'h0000, 16'h8000, 16'h8000, 16'h8000, 16'h8000};
    logic ex [6] = '{1, 0, 0, 0, 1, 0};
    wr(a_mk, 32'h1);
    for (int i = 0; i < 6; i++) begin
      cpu_pipe_sel <= sl[i];
      eng.set(6'h15, mo[i], fl[i], 1'b0);
      wr(a_cpu, {16'h0, dt[i]});
      rd(a_st, {31'h0, ex[i]});
      chk({31'h0, irq}, {31'h0, ex[i]});
      wr(a_st, 32'hf);
    end
    chk(n_tgl, 2);
    chk(n_val, 2);
  endtask
  task t_clear;
    cpu_pipe_sel <= 3'h2;
    eng.set(6'h15, 1'b0, 1'b0, 1'b1);
    wr(a_mk, 32'h2);
    rd(a_cpu, 32'h2000);
    eng.set(6'h15, 1'b0, 1'b0, 1'b0);
    rd(a_cpu, 32'h0);
    wr(a_cpu, 32'h4000);
    rd(a_st, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(a_st, 32'hf);
    cpu_pipe_sel <= 3'h0;
    wr(a_cpu, 32'h4000);
    rd(a_st, 32'h0);
    chk(n_clr, 1);
  endtask
  task t_cfg;
    wr(a_cfg, 32'hffff);
    rd(a_cfg, 32'ha607);
    chk({30'h0, wd, ten}, 32'h3);
    chk({31'h0, pen}, 32'h0);
    for (int p = 0; p < 8; p++) begin
      wr(a_cfg, 32'h4000 | 32'(p));
      chk({31'h0, pen}, {31'h0, p > 0 && p < 7});
      chk({29'h0, dpipe}, 32'(p));
    end
    chk(n_rrd, 3);
    chk(n_rwr, 3);
    chk(n_tcl, 1);
    wr(a_cfg, 32'h0001);
    chk({30'h0, wd, ten}, 32'h0);
  endtask
  task t_len;
    wr(a_cfg, 32'h8001);
    eng.load(10'd10);
    eng.rd(1'b0);
    rd(a_len, 32'd9);
    wr(a_cfg, 32'h8401);
    eng.rd(1'b0);
    rd(a_len, 32'd7);
    wr(a_st, 32'hf);
    wr(a_cfg, 32'h2001);
    eng.load(10'd5);
    eng.rd(1'b0);
    rd(a_len, 32'd5);
    eng.rd(1'b1);
    rd(a_len, 32'd0);
    rd(a_st, 32'hc);
    wr(a_st, 32'hf);
    wr(a_cfg, 32'h0001);
    eng.rd(1'b1);
    rd(a_st, 32'h8);
    chk(n_abc, 1);
    wr(a_cfg, 32'h8007);
    eng.load(10'd3);
    eng.rd(1'b1);
    rd(a_len, 32'd3);
  endtask
  task t_soft;
    wr(a_cfg, 32'h0601);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    @(posedge mclk);
    rd(a_cfg, 32'h0);
    chk({29'h0, wd, ten, pen}, 32'h0);
  endtask
  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #400000;
    fail_count++;
    end_sim;
  end
  initial begin
    {reset, soft_reset, psel, penable, pwrite} = 5'h10;
    {paddr, pwdata, cpu_pipe_sel} = 47'h0;
    fail_count = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_toggle;
    t_clear;
    t_cfg;
    t_len;
    t_soft;
    end_sim;
  end
endmodule
`default_nettype wire
